// ### rtl/irq_pkg.sv
// Constants, register map and field layout of the interrupt controller
package irq_pkg;
    // ==========================================================
    // Source counts and priority numbers
    localparam int NUM_REQ = 15;
    localparam int NUM_PIN = 13;
    localparam int NUM_KEY = 8;
    localparam logic [4:0] PRIO_RESET = 5'h01;
    localparam logic [4:0] PRIO_FIRST_MASKABLE = 5'h02;
    localparam logic [4:0] PRIO_BREAK = 5'h11;
    // ==========================================================
    // Request bit positions, priority minus two
    localparam int REQ_EXT_A = 0;
    localparam int REQ_EXT_B = 1;
    localparam int REQ_EXT_C = 2;
    localparam int REQ_KEY = 3;
    localparam int REQ_AUX_TMR = 4;
    localparam int REQ_TMR0 = 5;
    localparam int REQ_SER_A_RX = 9;
    localparam int REQ_SER_A_TX = 10;
    localparam int REQ_SER_B = 11;
    localparam int REQ_CNT_A = 12;
    localparam int REQ_SHARED = 13;
    localparam int REQ_ADC = 14;
    // ==========================================================
    // Pin vector layout inside the edge sensor
    localparam int PIN_EXT_A = 0;
    localparam int PIN_EXT_B = 1;
    localparam int PIN_EXT_C = 2;
    localparam int PIN_CNT_A = 3;
    localparam int PIN_CNT_B = 4;
    localparam int PIN_KEY0 = 5;
    localparam logic [12:0] PIN_RESET_LVL = 13'h1fff;
    // ==========================================================
    // Vector addresses: low byte of reset, two bytes per level
    localparam logic [15:0] VEC_RESET_LO = 16'hfffc;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_REQ = 8'h00;
    localparam logic [7:0] OFS_EN = 8'h04;
    localparam logic [7:0] OFS_SEL = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // ==========================================================
    // Select register fields: bits 4..0 rising-edge choice
    localparam int SEL_POL_LSB = 0;
    localparam int SEL_KEY = 5;
    localparam int SEL_SER_A = 6;
    localparam int SEL_CNT_B = 7;
    localparam int SEL_W = 8;
    localparam logic [7:0] SEL_RESET = 8'h00;
    // Status register fields
    localparam int STAT_PEND = 0;
    localparam int STAT_FLAG = 1;
    localparam int STAT_IDX_LSB = 8;
endpackage

// ### rtl/pin_sense_if.sv
// Synchronised pin levels and edge pulses passed to the controller
`timescale 1ns/100ps
interface pin_sense_if;
    logic [12:0] lvl;
    logic [12:0] rise;
    logic [12:0] fall;
    modport sense (output lvl, output rise, output fall);
    modport use_side (input lvl, input rise, input fall);
endinterface

// ### rtl/pin_edge_sense.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module pin_edge_sense
    import irq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [12:0] pin_raw,
    pin_sense_if.sense ps
);
    logic [12:0] sync1_reg;
    logic [12:0] sync2_reg;
    logic [12:0] sync3_reg;
    logic [12:0] stable_reg;
    logic [12:0] rise_reg;
    logic [12:0] fall_reg;
    logic [12:0] agree;
    logic [12:0] change;

    // ==========================================================
    // Synchroniser chain; first stage feeds only the second
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= PIN_RESET_LVL;
            sync2_reg <= PIN_RESET_LVL;
            sync3_reg <= PIN_RESET_LVL;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A level counts only once stages two and three agree
    assign agree = ~(sync2_reg ^ sync3_reg);
    assign change = agree & (sync3_reg ^ stable_reg);

    // Filtered level and one-cycle edge pulses
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stable_reg <= PIN_RESET_LVL;
            rise_reg <= 13'h0000;
            fall_reg <= 13'h0000;
        end else begin
            stable_reg <= (stable_reg & ~agree) | (sync3_reg & agree);
            rise_reg <= change & sync3_reg;
            fall_reg <= change & ~sync3_reg;
        end
    end

    assign ps.lvl = stable_reg;
    assign ps.rise = rise_reg;
    assign ps.fall = fall_reg;
endmodule

// ### rtl/vectored_irq_ctrl.sv
// Fixed-priority vectored interrupt controller with AHB-Lite registers
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module vectored_irq_ctrl
    import irq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic ext_edge_irq_a,
    input wire logic ext_edge_irq_b,
    input wire logic ext_edge_irq_c,
    input wire logic counter_pin_irq_a,
    input wire logic counter_pin_irq_b,
    input wire logic [7:0] key_in,
    input wire logic aux_timer_uf,
    input wire logic [3:0] timer_uf,
    input wire logic timer_y_uf,
    input wire logic serial_channel_a_rx_done,
    input wire logic serial_channel_a_tx_done,
    input wire logic serial_channel_b_done,
    input wire logic adc_done,
    input wire logic software_break,
    input wire logic instr_boundary,
    input wire logic return_from_irq,
    output logic irq_pending,
    output logic irq_take,
    output logic [4:0] vec_index,
    output logic [15:0] vec_addr_lo,
    output logic irq_disable
);
    // ==========================================================
    // Helpers
    // Lowest set bit gives the priority number, bit zero first
    function automatic logic [4:0] first_prio(input logic [16:0] v);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 16; i >= 0; i--) begin
            if (v[i]) begin
                p = 5'(i + 1);
            end
        end
        return p;
    endfunction

    // Low vector byte address of a priority level
    function automatic logic [15:0] vec_lo(input logic [4:0] prio);
        return 16'(VEC_RESET_LO - VEC_STEP * 16'(prio - PRIO_RESET));
    endfunction

    // Priority is maskable when it owns a request bit
    function automatic logic is_maskable(input logic [4:0] prio);
        return (prio >= PRIO_FIRST_MASKABLE) && (prio < PRIO_BREAK);
    endfunction

    // ==========================================================
    // Declarations
    pin_sense_if ps ();
    logic [NUM_REQ-1:0] req_reg;
    logic [NUM_REQ-1:0] en_reg;
    logic [SEL_W-1:0] sel_reg;
    logic flag_reg;
    logic saved_flag_reg;
    logic rst_pend_reg;
    logic brk_pend_reg;
    logic key_and_reg;
    logic irq_pending_reg;
    logic irq_take_reg;
    logic [4:0] vec_index_reg;
    logic [15:0] vec_addr_reg;
    logic ap_valid_reg;
    logic ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic [31:0] hrdata_reg;
    logic [NUM_REQ-1:0] req_set;
    logic [NUM_REQ-1:0] req_next;
    logic [4:0] pin_edge;
    logic key_and;
    logic [16:0] elig;
    logic [4:0] win_prio;
    logic [3:0] win_bit;
    logic take_now;
    logic ap_take;
    logic wr_fire;
    logic [31:0] status_word;
    logic boundary_brk_only;

    // ==========================================================
    // Pin edge sensing
    pin_edge_sense u_sense (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin_raw({key_in, counter_pin_irq_b, counter_pin_irq_a,
                  ext_edge_irq_c, ext_edge_irq_b, ext_edge_irq_a}),
        .ps(ps)
    );

    // Polarity bit high picks the rising edge
    assign pin_edge = (ps.rise[4:0] & sel_reg[SEL_POL_LSB +: 5])
        | (ps.fall[4:0] & ~sel_reg[SEL_POL_LSB +: 5]);
    assign key_and = &ps.lvl[PIN_KEY0 +: NUM_KEY];

    // Previous key AND level for the falling detector
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            key_and_reg <= 1'b1;
        end else begin
            key_and_reg <= key_and;
        end
    end

    // ==========================================================
    // Request sources
    always_comb begin
        req_set = '0;
        req_set[REQ_EXT_A] = pin_edge[PIN_EXT_A];
        req_set[REQ_EXT_B] = pin_edge[PIN_EXT_B];
        req_set[REQ_EXT_C] = pin_edge[PIN_EXT_C]
            & ~sel_reg[SEL_KEY];
        req_set[REQ_KEY] = key_and_reg & ~key_and
            & sel_reg[SEL_KEY];
        req_set[REQ_AUX_TMR] = aux_timer_uf;
        req_set[REQ_TMR0 +: 4] = timer_uf;
        req_set[REQ_SER_A_RX] = serial_channel_a_rx_done
            & sel_reg[SEL_SER_A];
        req_set[REQ_SER_A_TX] = serial_channel_a_tx_done
            & sel_reg[SEL_SER_A];
        req_set[REQ_SER_B] = serial_channel_b_done;
        req_set[REQ_CNT_A] = pin_edge[PIN_CNT_A];
        req_set[REQ_SHARED] = sel_reg[SEL_CNT_B]
            ? pin_edge[PIN_CNT_B] : timer_y_uf;
        req_set[REQ_ADC] = adc_done;
    end

    // ==========================================================
    // Arbitration; reset first, break last and never masked
    assign elig = {brk_pend_reg,
                   req_reg & en_reg & {NUM_REQ{~flag_reg}},
                   rst_pend_reg};
    assign win_prio = first_prio(elig);
    assign win_bit = 4'(win_prio - PRIO_FIRST_MASKABLE);
    assign take_now = instr_boundary && (elig != 17'h00000);

    // ==========================================================
    // Bus address phase capture; reads sampled here
    assign ap_take = hsel && htrans[1] && hready;
    assign wr_fire = ap_valid_reg && ap_write_reg;
    assign status_word = {16'h0000, 3'h0, vec_index_reg,
                          6'h00, flag_reg, irq_pending_reg};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
        end else if (hready) begin
            ap_valid_reg <= ap_take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr[7:0];
        end
    end

    // Read data registered; unmapped offsets read zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata_reg <= 32'h00000000;
        end else if (ap_take && !hwrite) begin
            unique case (haddr[7:0])
                OFS_REQ: hrdata_reg <= 32'(req_reg);
                OFS_EN: hrdata_reg <= 32'(en_reg);
                OFS_SEL: hrdata_reg <= 32'(sel_reg);
                OFS_FLAG: hrdata_reg <= 32'(flag_reg);
                OFS_STATUS: hrdata_reg <= status_word;
                default: hrdata_reg <= 32'h00000000;
            endcase
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    // ==========================================================
    // Request bits: a write can only clear, a new event wins
    always_comb begin
        req_next = req_reg;
        if (wr_fire && ap_addr_reg == OFS_REQ) begin
            req_next = req_next & hwdata[NUM_REQ-1:0];
        end
        if (take_now && is_maskable(win_prio)) begin
            req_next[win_bit] = 1'b0;
        end
        req_next = req_next | req_set;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            req_reg <= '0;
        end else begin
            req_reg <= req_next;
        end
    end

    // Enable and select registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            en_reg <= '0;
            sel_reg <= SEL_RESET;
        end else if (wr_fire) begin
            if (ap_addr_reg == OFS_EN) begin
                en_reg <= hwdata[NUM_REQ-1:0];
            end
            if (ap_addr_reg == OFS_SEL) begin
                sel_reg <= hwdata[SEL_W-1:0];
            end
        end
    end

    // ==========================================================
    // Disable flag: acceptance beats return, return beats software
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= 1'b1;
            saved_flag_reg <= 1'b1;
        end else if (take_now) begin
            flag_reg <= 1'b1;
            saved_flag_reg <= flag_reg;
        end else if (return_from_irq) begin
            flag_reg <= saved_flag_reg;
        end else if (wr_fire && ap_addr_reg == OFS_FLAG) begin
            flag_reg <= hwdata[0];
        end
    end

    // Reset and break latches; break has no request bit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_pend_reg <= 1'b1;
            brk_pend_reg <= 1'b0;
        end else begin
            if (take_now && win_prio == PRIO_RESET) begin
                rst_pend_reg <= 1'b0;
            end
            if (software_break) begin
                brk_pend_reg <= 1'b1;
            end else if (take_now && win_prio == PRIO_BREAK) begin
                brk_pend_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Core hand-off, sampled only at instruction boundaries
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_pending_reg <= 1'b0;
            irq_take_reg <= 1'b0;
            vec_index_reg <= 5'h00;
            vec_addr_reg <= 16'h0000;
        end else begin
            irq_take_reg <= take_now;
            if (instr_boundary) begin
                irq_pending_reg <= take_now;
            end
            if (take_now) begin
                vec_index_reg <= win_prio;
                vec_addr_reg <= vec_lo(win_prio);
            end
        end
    end

    assign irq_pending = irq_pending_reg;
    assign irq_take = irq_take_reg;
    assign vec_index = vec_index_reg;
    assign vec_addr_lo = vec_addr_reg;
    assign irq_disable = flag_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_mask_gate: assert property (
        take_now && is_maskable(win_prio) |->
            !flag_reg && req_reg[win_bit] && en_reg[win_bit])
        else $error("maskable request taken while gated");
    a_no_sw_set: assert property (
        ((req_reg & ~$past(req_reg)) & ~$past(req_set)) == '0)
        else $error("request bit rose without a source event");
    a_flag_on_take: assert property (
        take_now |=> flag_reg && irq_take_reg)
        else $error("disable flag not set on acceptance");
    a_bit_cleared: assert property (
        take_now && is_maskable(win_prio) && !req_set[win_bit] |=>
            !req_reg[$past(win_bit)])
        else $error("accepted request bit not cleared");
    a_highest_wins: assert property (
        take_now |-> (elig & (~elig + 17'h00001))
            == (17'h00001 << (win_prio - PRIO_RESET)))
        else $error("winner is not the highest priority");
    a_vector_addr: assert property (
        irq_take_reg && vec_index_reg == PRIO_RESET |->
            vec_addr_reg == 16'hfffc)
        else $error("reset vector address wrong");
    a_break_vector: assert property (
        boundary_brk_only |=> vec_addr_reg == 16'hffdc
            && vec_index_reg == 5'h11)
        else $error("break not taken on its vector");
    a_shared_sel: assert property (
        !sel_reg[SEL_CNT_B] && !timer_y_uf |-> !req_set[REQ_SHARED])
        else $error("unselected shared source raised request");
    a_shared_cntb: assert property (
        sel_reg[SEL_CNT_B] && !pin_edge[PIN_CNT_B] |-> !req_set[REQ_SHARED])
        else $error("timer event leaked into counter slot");
    a_key_sel: assert property (
        !sel_reg[SEL_KEY] |-> !req_set[REQ_KEY])
        else $error("key request while key not selected");
    a_pend_hold: assert property (
        !instr_boundary |=> irq_pending_reg == $past(irq_pending_reg))
        else $error("pending changed between boundaries");

    // Boundary where only the break latch is eligible
    assign boundary_brk_only = instr_boundary && elig == 17'h10000;

    c_reset_taken: cover property (irq_take_reg && vec_index_reg == 5'h01);
    c_break_taken: cover property (boundary_brk_only ##1 irq_take_reg);
    c_two_pending: cover property (take_now && $countones(elig) > 1);
    c_shared_taken: cover property (take_now && win_prio == 5'h0f);
endmodule

// ### testbench/event_source_model.sv
// Peripheral event model: timers, serial channels, converter, break
`timescale 1ns/100ps
module event_source_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [17:0] fire_mask,
    output logic aux_timer_uf,
    output logic [3:0] timer_uf,
    output logic timer_y_uf,
    output logic serial_channel_a_rx_done,
    output logic serial_channel_a_tx_done,
    output logic serial_channel_b_done,
    output logic adc_done,
    output logic software_break
);
    logic [17:0] pulse_reg;
    // ==========================================================
    // Pulse stage, bit n is the source at priority n
    // Registered so pulses launch from the clock like real peripherals
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pulse_reg <= '0;
        end else begin
            pulse_reg <= fire_mask;
        end
    end
    // One-cycle event pulses
    assign aux_timer_uf = pulse_reg[6];
    assign timer_uf = pulse_reg[10:7];
    assign serial_channel_a_rx_done = pulse_reg[11];
    assign serial_channel_a_tx_done = pulse_reg[12];
    assign serial_channel_b_done = pulse_reg[13];
    assign timer_y_uf = pulse_reg[15];
    assign adc_done = pulse_reg[16];
    assign software_break = pulse_reg[17];
endmodule

// ### testbench/vectored_fixed_priority_interrupts_tb.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("CHECK FAILED t=%0t got %h exp %h", \
    $time, g, e); end end
module vectored_fixed_priority_interrupts_tb;
    import irq_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic ext_edge_irq_a = 1'b1;
    logic ext_edge_irq_b = 1'b1;
    logic ext_edge_irq_c = 1'b1;
    logic counter_pin_irq_a = 1'b1;
    logic counter_pin_irq_b = 1'b1;
    logic [7:0] key_in = 8'hff;
    logic [17:0] fire_mask = '0;
    logic instr_boundary = 1'b0;
    logic return_from_irq = 1'b0;
    logic irq_pending, irq_take, irq_disable;
    logic [4:0] vec_index;
    logic [15:0] vec_addr_lo;
    logic aux_uf, ty_uf, sa_rx, sa_tx, sb_done, adc, brk_ev;
    logic [3:0] t_uf;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [4:0] plist [10] = '{6, 7, 8, 9, 10, 11, 12, 13, 15, 16};
    // Single slave: its ready is the bus ready
    assign hready = hreadyout;
    always #5 clk_sys = ~clk_sys;
    vectored_irq_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .ext_edge_irq_a(ext_edge_irq_a),
        .ext_edge_irq_b(ext_edge_irq_b), .ext_edge_irq_c(ext_edge_irq_c),
        .counter_pin_irq_a(counter_pin_irq_a),
        .counter_pin_irq_b(counter_pin_irq_b), .key_in(key_in),
        .aux_timer_uf(aux_uf), .timer_uf(t_uf), .timer_y_uf(ty_uf),
        .serial_channel_a_rx_done(sa_rx), .serial_channel_a_tx_done(sa_tx),
        .serial_channel_b_done(sb_done), .adc_done(adc),
        .software_break(brk_ev), .instr_boundary(instr_boundary),
        .return_from_irq(return_from_irq), .irq_pending(irq_pending),
        .irq_take(irq_take), .vec_index(vec_index),
        .vec_addr_lo(vec_addr_lo), .irq_disable(irq_disable));
    event_source_model events (.clk_sys(clk_sys), .nrst(nrst),
        .fire_mask(fire_mask), .aux_timer_uf(aux_uf), .timer_uf(t_uf),
        .timer_y_uf(ty_uf), .serial_channel_a_rx_done(sa_rx),
        .serial_channel_a_tx_done(sa_tx), .serial_channel_b_done(sb_done),
        .adc_done(adc), .software_break(brk_ev));
    // ==========================================================
    // Bus tasks; the master never assumes a wait count
    task addr_phase(input logic [7:0] a, input logic w);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
    endtask
    task ahb_write(input logic [7:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
    endtask
    task chk_reg(input logic [7:0] a, input logic [31:0] e);
        addr_phase(a, 1'b0);
        do @(posedge clk_sys); while (hready !== 1'b1);
        `CHK(hrdata, e)
        `CHK(hresp, 1'b0)
    endtask
    // ==========================================================
    // Core side tasks
    task fire(input logic [17:0] m);
        @(posedge clk_sys);
        fire_mask <= m;
        @(posedge clk_sys);
        fire_mask <= '0;
    endtask
    task boundary;
        @(posedge clk_sys);
        instr_boundary <= 1'b1;
        @(posedge clk_sys);
        instr_boundary <= 1'b0;
        #1;
    endtask
    task accept(input logic [4:0] p);
        boundary();
        `CHK(irq_take, 1'b1)
        `CHK(irq_pending, 1'b1)
        `CHK(vec_index, p)
        `CHK(vec_addr_lo, VEC_RESET_LO - {10'h0, p - 5'h01, 1'b0})
        `CHK(irq_disable, 1'b1)
        @(posedge clk_sys);
        #1;
        `CHK(irq_take, 1'b0)
    endtask
    task open_accept(input logic [4:0] p);
        ahb_write(OFS_FLAG, 32'h0);
        accept(p);
    endtask
    task refuse;
        boundary();
        `CHK(irq_take, 1'b0)
        `CHK(irq_pending, 1'b0)
    endtask
    // Pin path is synchroniser plus edge stage, well inside eight
    task settle;
        repeat (8) @(posedge clk_sys);
    endtask
    task print_verdict;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        chk_reg(OFS_FLAG, 32'h1);
        accept(PRIO_RESET);
        ahb_write(OFS_EN, 32'h7fff);
        ahb_write(OFS_SEL, 32'h40);
        ahb_write(OFS_REQ, 32'h0);
        for (int i = 0; i < 10; i++) begin
            ahb_write(OFS_FLAG, 32'h0);
            fire(18'h1 << plist[i]);
            accept(plist[i]);
            chk_reg(OFS_REQ, 32'h0);
        end
        // Flag is set here, break must still get through
        fire(18'h20000);
        accept(PRIO_BREAK);
        ahb_write(OFS_EN, 32'h3fff);
        ahb_write(OFS_FLAG, 32'h0);
        fire(18'h10000);
        refuse();
        chk_reg(OFS_REQ, 32'h4000);
        ahb_write(OFS_REQ, 32'h7fff);
        chk_reg(OFS_REQ, 32'h4000);
        ahb_write(OFS_REQ, 32'h0);
        chk_reg(OFS_REQ, 32'h0);
        ahb_write(OFS_EN, 32'h7fff);
        ahb_write(OFS_FLAG, 32'h1);
        fire(18'h40);
        refuse();
        open_accept(5'h06);
        // Three at once: winner taken, losers kept
        ahb_write(OFS_FLAG, 32'h0);
        fire(18'h11080);
        accept(5'h07);
        chk_reg(OFS_REQ, 32'h4400);
        open_accept(5'h0c);
        open_accept(5'h10);
        @(posedge clk_sys);
        return_from_irq <= 1'b1;
        @(posedge clk_sys);
        return_from_irq <= 1'b0;
        #1;
        `CHK(irq_disable, 1'b0)
        ahb_write(OFS_SEL, 32'h00);
        fire(18'h800);
        refuse();
        ahb_write(OFS_SEL, 32'h80);
        ahb_write(OFS_REQ, 32'h0);
        fire(18'h8000);
        refuse();
        @(posedge clk_sys);
        counter_pin_irq_b <= 1'b0;
        settle();
        accept(5'h0f);
        // Pin edges: ext a rising, the others falling
        ahb_write(OFS_SEL, 32'h81);
        ahb_write(OFS_REQ, 32'h0);
        @(posedge clk_sys);
        ext_edge_irq_a <= 1'b0;
        ext_edge_irq_b <= 1'b0;
        counter_pin_irq_a <= 1'b0;
        settle();
        chk_reg(OFS_REQ, 32'h1002);
        @(posedge clk_sys);
        ext_edge_irq_a <= 1'b1;
        settle();
        chk_reg(OFS_REQ, 32'h1003);
        open_accept(5'h02);
        open_accept(5'h03);
        open_accept(5'h0e);
        // Ext c selected: key ignored
        @(posedge clk_sys);
        key_in <= 8'hfe;
        ext_edge_irq_c <= 1'b0;
        settle();
        chk_reg(OFS_REQ, 32'h0004);
        @(posedge clk_sys);
        key_in <= 8'hff;
        ext_edge_irq_c <= 1'b1;
        ahb_write(OFS_SEL, 32'ha1);
        ahb_write(OFS_REQ, 32'h0);
        @(posedge clk_sys);
        key_in <= 8'hf7;
        ext_edge_irq_c <= 1'b0;
        settle();
        chk_reg(OFS_REQ, 32'h0008);
        open_accept(5'h05);
        chk_reg(OFS_STATUS, 32'h0503);
        print_verdict();
    end
endmodule
